// ---- design/eee_regs_pkg.sv ----
package eee_regs_pkg;

  // Register offsets on the host register port
  localparam logic [7:0] ADVERTISE_OFS  = 8'he0;
  localparam logic [7:0] WAKE_ERR_OFS   = 8'he2;
  localparam logic [7:0] CTRL_STAT_OFS  = 8'he4;

  // Field positions, advertisement register
  localparam int PARTNER_LSB    = 9;
  localparam int PARTNER_MSB    = 14;
  localparam int LOCAL_FIX_LSB  = 2;
  localparam int LOCAL_FIX_MSB  = 6;
  localparam int LOCAL_TX_BIT   = 1;

  // Field positions, control/status register
  localparam int CS_SPARE_BIT   = 15;
  localparam int CS_HW_EN_BIT   = 14;
  localparam int CS_TX_LATCH    = 13;
  localparam int CS_TX_LIVE     = 12;

  // Reset values
  localparam logic [5:0]  PARTNER_RST   = 6'h00;
  localparam logic [4:0]  LOCAL_FIX_VAL = 5'h00;
  localparam logic        LOCAL_TX_RST  = 1'b1;
  localparam logic        CS_SPARE_RST  = 1'b1;
  localparam logic [15:0] WAKE_ERR_RST  = 16'h0000;

  // Wake time limit; longer than this counts as a wake error
  localparam int WAKE_LIMIT_PS  = 20500000;
  localparam int CLK_PERIOD_PS  = 10000;
  localparam int WAKE_CYCLES    = (WAKE_LIMIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef struct packed {
    logic [7:0]  addr;
    logic        wr;
    logic        rd;
    logic [1:0]  be;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [5:0]  partner_abil;
    logic        hw_eee_en;
    logic        tx_lpi;
    logic        wake_pending;
  } pcs_status_t;

endpackage

// ---- design/port_eee_status_registers.sv ----
`timescale 1ns/1ps
module port_eee_status_registers
  import eee_regs_pkg::*;
#(
  parameter int WAKE_LIMIT_CYC = WAKE_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire reg_req_t    req,
  input  wire pcs_status_t pcs,
  output logic [15:0]      rdata_q,
  output logic             rvalid_q
);

  // Reset lifts two edges after release, but still asserts at once
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // Register select, shared by every decode
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    return (addr == ofs);
  endfunction

  // Address decode
  wire sel_adv  = addr_hit(req.addr, ADVERTISE_OFS);
  wire sel_wake = addr_hit(req.addr, WAKE_ERR_OFS);
  wire sel_cs   = addr_hit(req.addr, CTRL_STAT_OFS);
  wire wr_adv   = req.wr && sel_adv;
  wire wr_cs    = req.wr && sel_cs;
  wire rd_wake  = req.rd && sel_wake;

  // Byte lanes: be[0] carries bits 7..0, be[1] bits 15..8
  wire wr_adv_lo = wr_adv && req.be[0];
  wire wr_cs_hi  = wr_cs && req.be[1];

  localparam int CNT_W = $clog2(WAKE_LIMIT_CYC + 1);

  // Register state
  logic [5:0]  partner_q;
  logic        local_tx_q;
  logic        spare_q;
  logic        hw_en_q;
  logic        tx_live_q;
  logic        tx_latch_q;
  logic [15:0] wake_err_q;
  logic        done_q;
  logic [CNT_W-1:0] wake_cnt_q;

  // wake timer; it stops at the limit so one wake gives one event
  wire [CNT_W-1:0] wake_limit = WAKE_LIMIT_CYC[CNT_W-1:0];
  wire             wake_done  = pcs.wake_pending && (wake_cnt_q == wake_limit);
  wire [CNT_W-1:0] wake_cnt_d =
    !pcs.wake_pending ? '0 : (wake_done ? wake_cnt_q : wake_cnt_q + 1'b1);

  wire wake_evt = wake_done && !done_q;

  wire [15:0] wake_inc = (wake_err_q == 16'hffff) ? wake_err_q : wake_err_q + 16'h0001;
  // read clears; event during read leaves one
  wire [15:0] wake_err_d = rd_wake ? {15'h0000, wake_evt} : (wake_evt ? wake_inc : wake_err_q);

  // write one clears; new LPI wins over the clear
  wire tx_clr     = wr_cs_hi && req.wdata[CS_TX_LATCH];
  wire tx_latch_d = pcs.tx_lpi || (tx_latch_q && !tx_clr);

  wire local_tx_d = wr_adv_lo ? req.wdata[LOCAL_TX_BIT] : local_tx_q;
  wire spare_d    = wr_cs_hi ? req.wdata[CS_SPARE_BIT] : spare_q;

  wire [15:0] adv_word;
  assign adv_word[15]                      = 1'b0;
  assign adv_word[PARTNER_MSB:PARTNER_LSB] = partner_q;
  assign adv_word[8:7]                     = 2'b00;
  assign adv_word[LOCAL_FIX_MSB:LOCAL_FIX_LSB] = LOCAL_FIX_VAL;
  assign adv_word[LOCAL_TX_BIT]            = local_tx_q;
  assign adv_word[0]                       = 1'b0;

  wire [15:0] cs_word;
  assign cs_word[CS_SPARE_BIT] = spare_q;
  assign cs_word[CS_HW_EN_BIT] = hw_en_q;
  assign cs_word[CS_TX_LATCH]  = tx_latch_q;
  assign cs_word[CS_TX_LIVE]   = tx_live_q;
  assign cs_word[11:0]         = 12'h000;

  // Read selection; unmapped offsets read as zero
  wire [15:0] rd_mux = sel_adv  ? adv_word :
                       sel_wake ? wake_err_q :
                       sel_cs   ? cs_word : 16'h0000;

  // partner abilities, one flop per advertised mode
  // Status bit 0 lands on register bit 9
  localparam int PARTNER_W = PARTNER_MSB - PARTNER_LSB + 1;
  for (genvar i = 0; i < PARTNER_W; i++) begin : g_partner
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
        partner_q[i] <= PARTNER_RST[i];
      end else begin
        partner_q[i] <= pcs.partner_abil[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      local_tx_q <= LOCAL_TX_RST;
    end else begin
      local_tx_q <= local_tx_d;
    end
  end

  // Spare control bit, writable
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      spare_q <= CS_SPARE_RST;
    end else begin
      spare_q <= spare_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hw_en_q <= 1'b0;
    end else begin
      hw_en_q <= pcs.hw_eee_en;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_live_q <= 1'b0;
    end else begin
      tx_live_q <= pcs.tx_lpi;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_latch_q <= 1'b0;
    end else begin
      tx_latch_q <= tx_latch_d;
    end
  end

  // wake error count, read clear, overlap
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wake_err_q <= WAKE_ERR_RST;
    end else begin
      wake_err_q <= wake_err_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      done_q <= 1'b0;
    end else begin
      done_q <= wake_done;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wake_cnt_q <= '0;
    end else begin
      wake_cnt_q <= wake_cnt_d;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= req.rd ? rd_mux : rdata_q;
    end
  end

  // Read valid pulse
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req.rd;
    end
  end

endmodule

// ---- bench/eee_regs_props.sv ----
`timescale 1ns/1ps
module eee_regs_props
  import eee_regs_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire reg_req_t    req,
  input wire pcs_status_t pcs,
  input wire logic [15:0] rdata_q,
  input wire logic        rvalid_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence rd_at(logic [7:0] a);
    req.rd && req.addr == a;
  endsequence
  sequence cs_clr;
    !pcs.tx_lpi [*2] ##0 req.wr && req.be[1] && req.wdata[CS_TX_LATCH]
      && req.addr == CTRL_STAT_OFS;
  endsequence
  AST_RVALID: assert property (rvalid_q == $past(req.rd))
    else $error("bad rvalid");
  AST_ADV_RO: assert property (rd_at(ADVERTISE_OFS) |=>
    rdata_q[8:2] == 7'h00 && !rdata_q[15] && !rdata_q[0]) else $error("bad adv fixed");
  AST_PARTNER: assert property (rd_at(ADVERTISE_OFS) |=>
    rdata_q[14:9] == $past(pcs.partner_abil, 2)) else $error("bad partner");
  AST_HW_EN: assert property (rd_at(CTRL_STAT_OFS) |=>
    rdata_q[14] == $past(pcs.hw_eee_en, 2)) else $error("bad hw enable");
  AST_LIVE: assert property (rd_at(CTRL_STAT_OFS) |=>
    rdata_q[12] == $past(pcs.tx_lpi, 2)) else $error("bad live lpi");
  AST_LATCH: assert property (pcs.tx_lpi ##1 !req.wr ##1 rd_at(CTRL_STAT_OFS) |=>
    rdata_q[13]) else $error("latch not set");
  AST_CLEAR: assert property (cs_clr ##1 !pcs.tx_lpi ##1 rd_at(CTRL_STAT_OFS) |=>
    !rdata_q[13]) else $error("latch not cleared");
  AST_RD_CLR: assert property (rd_at(WAKE_ERR_OFS) ##1 rd_at(WAKE_ERR_OFS) |=>
    rdata_q <= 16'h0001) else $error("count not cleared");
endmodule
bind port_eee_status_registers eee_regs_props u_eee_regs_props (.ref_clk, .arst_n, .req,
  .pcs, .rdata_q, .rvalid_q);

// ---- bench/port_eee_status_registers_tb.sv ----
`timescale 1ns/1ps
module port_eee_status_registers_tb;
  import eee_regs_pkg::*;
  localparam int WL = 10;
  logic        ref_clk   = 0;
  logic        arst_n    = 0;
  reg_req_t    req       = '0;
  pcs_status_t pcs       = '0;
  logic [15:0] rdata_q;
  logic        rvalid_q;
  int          n_fail    = 0;
  int          cmp_count = 0;
  port_eee_status_registers #(.WAKE_LIMIT_CYC(WL)) u_port_eee_status_registers (.ref_clk,
    .arst_n, .req, .pcs, .rdata_q, .rvalid_q);
  initial forever #5 ref_clk = ~ref_clk;
  task automatic wait_n(int n);
    req = '0;
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d, logic [1:0] b);
    req = '{a, 1'b1, 1'b0, b, d};
    @(negedge ref_clk);
  endtask
  task automatic rd(logic [7:0] a, logic [15:0] e);
    req = '{a, 1'b0, 1'b1, 2'b00, 16'h0000};
    @(negedge ref_clk);
    cmp_count++;
    if (rvalid_q !== 1'b1 || rdata_q !== e) begin
      n_fail++;
      $display("ERROR t=%0t got %h exp %h", $time, rdata_q, e);
    end
  endtask
  task automatic wake(int n);
    pcs.wake_pending = 1;
    wait_n(n);
    pcs.wake_pending = 0;
    wait_n(4);
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #20000;
    n_fail++;
    end_of_test();
  end
  initial begin
    wait_n(4);
    arst_n = 1;
    wait_n(3);
    rd(ADVERTISE_OFS, 16'h0002);
    rd(WAKE_ERR_OFS, 16'h0000);
    rd(CTRL_STAT_OFS, 16'h8000);
    rd(8'h10, 16'h0000);
    pcs.partner_abil = 6'h21;
    wr(ADVERTISE_OFS, 16'hffff, 2'b11);
    rd(ADVERTISE_OFS, 16'h4202);
    wr(ADVERTISE_OFS, 16'h0000, 2'b11);
    rd(ADVERTISE_OFS, 16'h4200);
    pcs.hw_eee_en = 1;
    pcs.tx_lpi = 1;
    wait_n(2);
    rd(CTRL_STAT_OFS, 16'hf000);
    pcs.tx_lpi = 0;
    wait_n(2);
    rd(CTRL_STAT_OFS, 16'he000);
    wr(CTRL_STAT_OFS, 16'h8000, 2'b11);
    rd(CTRL_STAT_OFS, 16'he000);
    wr(CTRL_STAT_OFS, 16'ha000, 2'b10);
    wait_n(1);
    rd(CTRL_STAT_OFS, 16'hc000);
    wr(ADVERTISE_OFS, 16'h0002, 2'b10);
    rd(ADVERTISE_OFS, 16'h4200);
    rd(CTRL_STAT_OFS, 16'hc000);
    pcs.hw_eee_en = 0;
    wait_n(1);
    rd(CTRL_STAT_OFS, 16'h8000);
    wake(WL - 2);
    wake(WL + 4);
    rd(WAKE_ERR_OFS, 16'h0001);
    rd(WAKE_ERR_OFS, 16'h0000);
    pcs.wake_pending = 1;
    wait_n(WL);
    rd(WAKE_ERR_OFS, 16'h0000);
    pcs.wake_pending = 0;
    wait_n(2);
    rd(WAKE_ERR_OFS, 16'h0001);
    wait_n(2);
    end_of_test();
  end
endmodule
